//--- hdl/fifo_storage_ram.sv
// dual-port word array of the fifo: one write port, one read port.
// assumes the caller never writes a full array or reads an empty one.
`timescale 1ns/1ps
`include "sync_fifo_prog_flags_params.svh"
module fifo_storage_ram
   import sync_fifo_types_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH_DEFAULT,
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);
   // ==========================================================
   // array, no reset: contents are only meaningful behind pointers
   logic [WIDTH-1:0] mem [DEPTH];

   // write port
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   // read port is asynchronous; the caller registers the word
   assign o_rdata = mem[i_raddr];
endmodule

//--- hdl/gray_ptr_sync.sv
// two-stage synchroniser for a gray coded pointer.
// assumes the sampling side's tick marks its clock edge.
`timescale 1ns/1ps
`include "sync_fifo_prog_flags_params.svh"
module gray_ptr_sync
   import sync_fifo_types_pkg::*;
#(
   parameter int PW = 7
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_tick, // sampling side edge
   input wire logic [PW-1:0] i_gray,
   output logic [PW-1:0] o_gray
);
   // ==========================================================
   // stages
   logic [PW-1:0] meta_q, meta_d; // first stage, seen only by the second
   logic [PW-1:0] sync_q, sync_d;

   // gray code keeps a torn sample to one bit of error
   always_comb begin
      meta_d = meta_q;
      sync_d = sync_q;
      if (i_tick) begin
         meta_d = i_gray;
         sync_d = meta_q;
      end
   end

   // registers only
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_gray = sync_q;
endmodule

//--- hdl/sync_fifo_prog_flags.sv
// programmable-flag fifo of 9-bit words with load-mode offset access.
// assumes one clock; write and read side edges arrive as one-cycle
// tick pulses, and all pins are synchronous to i_clk.
`timescale 1ns/1ps
`include "sync_fifo_prog_flags_params.svh"
module sync_fifo_prog_flags
   import sync_fifo_types_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_fifo_reset_n,
   input wire logic i_write_side_tick,
   input wire logic i_read_side_tick,
   input wire logic [`FIFO_WIDTH-1:0] i_data_in,
   input wire logic i_write_enable_primary_n,
   input wire logic i_write_enable2_or_load,
   input wire logic i_read_enable_a_n,
   input wire logic i_read_enable_b_n,
   input wire logic i_output_drive_enable_n,
   output logic [`FIFO_WIDTH-1:0] o_data_out,
   output logic o_data_out_oe,
   output logic o_empty_flag_n,
   output logic o_full_flag_n,
   output logic o_almost_empty_flag_n,
   output logic o_almost_full_flag_n
);
   // ==========================================================
   // sizes and checks
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1; // extra wrap bit tells full from empty
   localparam int CW = 17; // wide enough for offsets plus counts
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

   if (DEPTH < `FIFO_DEPTH_MIN || DEPTH > `FIFO_DEPTH_MAX || (1 << AW) != DEPTH) begin : g_chk
      $error("DEPTH must be a power of two from 64 to 8192");
   end

   // binary to gray
   function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
      to_gray = b ^ (b >> 1);
   endfunction

   // gray to binary
   function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = '0;
      for (int i = PW - 1; i >= 0; i--) begin
         b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
      end
      to_bin = b;
   endfunction

   // ==========================================================
   // reset and mode
   logic rst_all; // either house reset or the pin
   logic mode_two_q, mode_two_d; // 1: second write enable, 0: load pin

   // the pin reset is sampled, so running ticks cannot upset it
   assign rst_all = i_rst | ~i_fifo_reset_n;

   // mode is caught while the pin reset is held
   always_comb begin
      mode_two_d = mode_two_q;
      if (~i_fifo_reset_n) begin
         mode_two_d = i_write_enable2_or_load;
      end
   end

   // mode register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode_two_q <= `FIFO_MODE_RESET;
      end else begin
         mode_two_q <= mode_two_d;
      end
   end

   // ==========================================================
   // access decode
   logic load_active; // load pin low in flag mode
   logic ofs_wr; // offset register write this tick
   logic ofs_rd; // offset register read this tick
   logic wr_req; // fifo write request before full check
   logic rd_req; // fifo read request before empty check
   logic wr_do; // accepted write
   logic rd_do; // accepted read

   assign load_active = ~mode_two_q & ~i_write_enable2_or_load;
   assign ofs_wr = i_write_side_tick & load_active & ~i_write_enable_primary_n;
   assign ofs_rd = i_read_side_tick & load_active & ~i_read_enable_a_n
                   & ~i_read_enable_b_n;
   assign wr_req = i_write_side_tick & ~i_write_enable_primary_n
                   & i_write_enable2_or_load;
   assign rd_req = i_read_side_tick & ~load_active & ~i_read_enable_a_n
                   & ~i_read_enable_b_n;
   assign wr_do = wr_req & o_full_flag_n;
   assign rd_do = rd_req & o_empty_flag_n;

   // ==========================================================
   // offset registers
   logic [`FIFO_OFFSET_WIDTH-1:0] offset_q [4], offset_d [4];
   offset_sel_e sel_q, sel_d; // shared rotation pointer
   logic [15:0] n_ofs; // empty offset
   logic [15:0] m_ofs; // full offset

   // a write wins if both sides touch the offsets in one cycle
   always_comb begin
      offset_d = offset_q;
      sel_d = sel_q;
      if (ofs_wr) begin
         offset_d[sel_q] = i_data_in[`FIFO_OFFSET_WIDTH-1:0];
         sel_d = next_sel(sel_q);
      end else if (ofs_rd) begin
         sel_d = next_sel(sel_q);
      end
   end

   // pointer is not touched when the load pin rises
   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         offset_q[SEL_EMPTY_LO] <= `FIFO_OFFSET_DEFAULT;
         offset_q[SEL_EMPTY_HI] <= `FIFO_OFFSET_ZERO;
         offset_q[SEL_FULL_LO] <= `FIFO_OFFSET_DEFAULT;
         offset_q[SEL_FULL_HI] <= `FIFO_OFFSET_ZERO;
         sel_q <= SEL_EMPTY_LO;
      end else begin
         offset_q <= offset_d;
         sel_q <= sel_d;
      end
   end

   assign n_ofs = {offset_q[SEL_EMPTY_HI], offset_q[SEL_EMPTY_LO]};
   assign m_ofs = {offset_q[SEL_FULL_HI], offset_q[SEL_FULL_LO]};

   // ==========================================================
   // pointer crossings
   logic [PW-1:0] wptr_q, wptr_d, wgray_q, wgray_d;
   logic [PW-1:0] rptr_q, rptr_d, rgray_q, rgray_d;
   logic [PW-1:0] wgray_at_r; // write pointer seen by the read side
   logic [PW-1:0] rgray_at_w; // read pointer seen by the write side

   gray_ptr_sync #(.PW(PW)) u_w2r (
      .i_clk(i_clk),
      .i_rst(rst_all),
      .i_tick(i_read_side_tick),
      .i_gray(wgray_q),
      .o_gray(wgray_at_r)
   );

   gray_ptr_sync #(.PW(PW)) u_r2w (
      .i_clk(i_clk),
      .i_rst(rst_all),
      .i_tick(i_write_side_tick),
      .i_gray(rgray_q),
      .o_gray(rgray_at_w)
   );

   // ==========================================================
   // storage
   logic [`FIFO_WIDTH-1:0] ram_rdata;

   fifo_storage_ram #(.DEPTH(DEPTH), .WIDTH(`FIFO_WIDTH), .AW(AW)) u_ram (
      .i_clk(i_clk),
      .i_we(wr_do),
      .i_waddr(wptr_q[AW-1:0]),
      .i_wdata(i_data_in),
      .i_raddr(rptr_q[AW-1:0]),
      .o_rdata(ram_rdata)
   );

   // ==========================================================
   // write side: pointer, full and almost full
   logic full_n_q, full_n_d;
   logic afull_n_q, afull_n_d;
   logic [PW-1:0] wcount; // unread words as seen by the write side

   // flags follow only write ticks
   always_comb begin
      wptr_d = wptr_q;
      full_n_d = full_n_q;
      afull_n_d = afull_n_q;
      if (wr_do) begin
         wptr_d = wptr_q + PW'(1);
      end
      wcount = wptr_d - to_bin(rgray_at_w);
      if (i_write_side_tick) begin
         full_n_d = (CW'(wcount) != DEPTH_C);
         afull_n_d = (CW'(wcount) + CW'(m_ofs)) < DEPTH_C;
      end
      wgray_d = to_gray(wptr_d);
   end

   // write side registers
   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         wptr_q <= '0;
         wgray_q <= '0;
         full_n_q <= 1'b1;
         afull_n_q <= 1'b1;
      end else begin
         wptr_q <= wptr_d;
         wgray_q <= wgray_d;
         full_n_q <= full_n_d;
         afull_n_q <= afull_n_d;
      end
   end

   // ==========================================================
   // read side: pointer, output register, empty and almost empty
   logic empty_n_q, empty_n_d;
   logic aempty_n_q, aempty_n_d;
   logic [`FIFO_WIDTH-1:0] dout_q, dout_d;
   logic oe_q, oe_d;
   logic [PW-1:0] rcount; // unread words as seen by the read side

   // the output register moves only on an accepted read or an offset read
   always_comb begin
      rptr_d = rptr_q;
      empty_n_d = empty_n_q;
      aempty_n_d = aempty_n_q;
      dout_d = dout_q;
      oe_d = ~i_output_drive_enable_n;
      if (rd_do) begin
         rptr_d = rptr_q + PW'(1);
         dout_d = ram_rdata;
      end else if (ofs_rd) begin
         dout_d = {1'b0, offset_q[sel_q]};
      end
      rcount = to_bin(wgray_at_r) - rptr_d;
      if (i_read_side_tick) begin
         empty_n_d = (rcount != '0);
         aempty_n_d = CW'(rcount) > CW'(n_ofs);
      end
      rgray_d = to_gray(rptr_d);
   end

   // read side registers; output enable keeps following its pin
   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         rptr_q <= '0;
         rgray_q <= '0;
         empty_n_q <= 1'b0;
         aempty_n_q <= 1'b0;
         dout_q <= `FIFO_DATA_RESET;
      end else begin
         rptr_q <= rptr_d;
         rgray_q <= rgray_d;
         empty_n_q <= empty_n_d;
         aempty_n_q <= aempty_n_d;
         dout_q <= dout_d;
      end
   end

   // output enable register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   // outputs straight from registers
   assign o_data_out = dout_q;
   assign o_data_out_oe = oe_q;
   assign o_empty_flag_n = empty_n_q;
   assign o_full_flag_n = full_n_q;
   assign o_almost_empty_flag_n = aempty_n_q;
   assign o_almost_full_flag_n = afull_n_q;

   // ==========================================================
   // checks
   sequence s_reset_pulse;
      rst_all ##1 !rst_all;
   endsequence

   property p_reset_empty;
      @(posedge i_clk) s_reset_pulse |-> !o_empty_flag_n && rptr_q == '0 && wptr_q == '0;
   endproperty
   a_reset_empty: assert property (p_reset_empty) else $error("reset left fifo not empty");

   property p_reset_zero_out;
      @(posedge i_clk) s_reset_pulse |-> o_data_out == '0;
   endproperty
   a_reset_zero_out: assert property (p_reset_zero_out) else $error("data not zero after reset");

   property p_oe_follows;
      @(posedge i_clk) disable iff (i_rst) !$past(i_rst) |-> o_data_out_oe == !$past(i_output_drive_enable_n);
   endproperty
   a_oe_follows: assert property (p_oe_follows) else $error("output enable wrong");

   property p_mode_capture;
      @(posedge i_clk) disable iff (i_rst)
         !i_fifo_reset_n |=> mode_two_q == $past(i_write_enable2_or_load);
   endproperty
   a_mode_capture: assert property (p_mode_capture) else $error("mode not captured");

   property p_no_write_full;
      @(posedge i_clk) disable iff (rst_all) !o_full_flag_n |=> $stable(wptr_q);
   endproperty
   a_no_write_full: assert property (p_no_write_full) else $error("write while full");

   property p_hold_empty;
      @(posedge i_clk) disable iff (rst_all) !o_empty_flag_n && !ofs_rd |=> $stable(o_data_out);
   endproperty
   a_hold_empty: assert property (p_hold_empty) else $error("output moved while empty");

   property p_write_two;
      @(posedge i_clk) disable iff (rst_all)
         mode_two_q && i_write_side_tick && !i_write_enable_primary_n
         && i_write_enable2_or_load && o_full_flag_n |=> wptr_q == $past(wptr_q) + PW'(1);
   endproperty
   a_write_two: assert property (p_write_two) else $error("two-enable write lost");

   property p_write_load;
      @(posedge i_clk) disable iff (rst_all)
         !mode_two_q && i_write_side_tick && !i_write_enable_primary_n
         && i_write_enable2_or_load && o_full_flag_n |=> wptr_q == $past(wptr_q) + PW'(1);
   endproperty
   a_write_load: assert property (p_write_load) else $error("flag-mode write lost");

   property p_offset_rotate;
      @(posedge i_clk) disable iff (rst_all)
         ofs_wr |=> sel_q == next_sel($past(sel_q)) && $stable(wptr_q);
   endproperty
   a_offset_rotate: assert property (p_offset_rotate) else $error("offset rotation wrong");

   property p_read_advance;
      @(posedge i_clk) disable iff (rst_all)
         rd_do |=> rptr_q == $past(rptr_q) + PW'(1) && o_data_out == $past(ram_rdata);
   endproperty
   a_read_advance: assert property (p_read_advance) else $error("read did not advance");
endmodule

//--- hdl/sync_fifo_prog_flags_params.svh
// constants for the programmable-flag synchronous fifo: reset values,
// depth limits and synchroniser length.
// assumes it is included by bare name from the design files.
`ifndef SYNC_FIFO_PROG_FLAGS_PARAMS_SVH
`define SYNC_FIFO_PROG_FLAGS_PARAMS_SVH

// ==========================================================
// sizes
`define FIFO_WIDTH 9
`define FIFO_DEPTH_DEFAULT 64
`define FIFO_DEPTH_MIN 64
`define FIFO_DEPTH_MAX 8192
`define FIFO_OFFSET_WIDTH 8
`define FIFO_SYNC_STAGES 2

// ==========================================================
// reset values
`define FIFO_OFFSET_DEFAULT 8'h07
`define FIFO_OFFSET_ZERO 8'h00
`define FIFO_DATA_RESET 9'h000
`define FIFO_MODE_RESET 1'b1

`endif

//--- hdl/sync_fifo_types_pkg.sv
// types shared by the fifo design files: offset register selector.
// assumes nothing of its surroundings.
package sync_fifo_types_pkg;
   // ==========================================================
   // offset register rotation, gray coded along its cycle
   typedef enum logic [1:0] {
      SEL_EMPTY_LO = 2'h0,
      SEL_EMPTY_HI = 2'h1,
      SEL_FULL_LO = 2'h3,
      SEL_FULL_HI = 2'h2
   } offset_sel_e;

   // next register in the rotation, wrapping after full-high
   function automatic offset_sel_e next_sel(input offset_sel_e s);
      case (s)
         SEL_EMPTY_LO: next_sel = SEL_EMPTY_HI;
         SEL_EMPTY_HI: next_sel = SEL_FULL_LO;
         SEL_FULL_LO: next_sel = SEL_FULL_HI;
         default: next_sel = SEL_EMPTY_LO;
      endcase
   endfunction
endpackage

//--- verif/fifo_side_clocks.sv
// far-side stand-in: the free-running write-side and read-side clocks,
// given to the fifo as one-cycle tick pulses.
// assumes the bench's clock; i_slow makes the reader run at a third.
`timescale 1ns/1ps
module fifo_side_clocks (
   input wire logic i_clk,
   input wire logic i_slow,
   output logic o_write_side_tick,
   output logic o_read_side_tick
);
   // ==========================================================
   // tick generation
   logic [1:0] div_q = 2'h0; // read-side divider in slow mode
   // never stopped, not even in reset: board clocks run free
   always_ff @(posedge i_clk) begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      o_write_side_tick <= 1'b1;
      // slow reader shows flag latency over more clock edges
      o_read_side_tick <= !i_slow || div_q == 2'h0;
   end
endmodule

//--- verif/sync_fifo_prog_flags_bench.sv
// self-checking bench for the programmable-flag fifo: both modes,
// offset load and read-back, boundaries of every flag.
// assumes a 64-word build and the side ticks of fifo_side_clocks.
`timescale 1ns/1ps
`include "sync_fifo_prog_flags_params.svh"
module sync_fifo_prog_flags_bench;
   import sync_fifo_types_pkg::*;
   // ==========================================================
   // signals
   localparam int DEPTH = 64;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fifo_reset_n = 1'b1; // falls later, so reset sees an edge
   logic [8:0] data_in = 9'h000;
   logic write_enable_primary_n = 1'b1;
   logic write_enable2_or_load = 1'b1; // idle high suits both modes
   logic read_enable_a_n = 1'b1;
   logic read_enable_b_n = 1'b1;
   logic output_drive_enable_n = 1'b0;
   logic slow = 1'b0;
   logic wtick, rtick, data_out_oe;
   logic empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
   logic [8:0] data_out;
   wire [3:0] flags = {empty_flag_n, almost_empty_flag_n, full_flag_n, almost_full_flag_n};
   logic [8:0] ofs_wr [5] = '{9'h005, 9'h000, 9'h009, 9'h000, 9'h002};
   logic [8:0] ofs_rd [4] = '{9'h000, 9'h009, 9'h000, 9'h002};
   int n_mismatch = 0;
   int compares = 0;

   always #2.5 clk = ~clk;

   // ==========================================================
   // design and far side
   sync_fifo_prog_flags #(.DEPTH(DEPTH)) sync_fifo_prog_flags_i (
      .i_clk(clk), .i_rst(rst), .i_fifo_reset_n(fifo_reset_n),
      .i_write_side_tick(wtick), .i_read_side_tick(rtick), .i_data_in(data_in),
      .i_write_enable_primary_n(write_enable_primary_n),
      .i_write_enable2_or_load(write_enable2_or_load),
      .i_read_enable_a_n(read_enable_a_n), .i_read_enable_b_n(read_enable_b_n),
      .i_output_drive_enable_n(output_drive_enable_n), .o_data_out(data_out),
      .o_data_out_oe(data_out_oe), .o_empty_flag_n(empty_flag_n),
      .o_full_flag_n(full_flag_n), .o_almost_empty_flag_n(almost_empty_flag_n),
      .o_almost_full_flag_n(almost_full_flag_n));
   fifo_side_clocks fifo_side_clocks_i (
      .i_clk(clk), .i_slow(slow), .o_write_side_tick(wtick), .o_read_side_tick(rtick));

   // ==========================================================
   // tasks
   // one counted comparison
   task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // let the flags cross both sides, then compare {empty, a-empty, full, a-full}
   task automatic flags_are(input logic [3:0] exp);
      repeat (8) @(posedge clk);
      #1 check({5'h00, flags}, {5'h00, exp}, "flags");
   endtask

   // reset pulse with the mode level held throughout
   task automatic fifo_rst(input logic lvl);
      #1 fifo_reset_n = 1'b0;
      write_enable2_or_load = lvl;
      repeat (3) @(posedge clk);
      #1 fifo_reset_n = 1'b1;
      write_enable2_or_load = 1'b1;
      @(posedge clk);
      #1 check(data_out, 9'h000, "reset data");
      check({5'h00, flags}, 9'h003, "reset flags");
   endtask

   // writes held over cnt write-side edges; en2 low means load pin low
   task automatic put(input int cnt, input logic [8:0] base, input logic en2);
      for (int k = 0; k < cnt; k++) begin
         #1 data_in = base + 9'(k);
         write_enable_primary_n = 1'b0;
         write_enable2_or_load = en2;
         do @(posedge clk); while (wtick !== 1'b1);
      end
      #1 write_enable_primary_n = 1'b1;
      write_enable2_or_load = 1'b1;
   endtask

   // cnt taken reads, words counting from base; off reads offsets
   task automatic get(input int cnt, input logic [8:0] base, input logic off);
      #1 read_enable_a_n = 1'b0;
      read_enable_b_n = 1'b0;
      write_enable2_or_load = !off;
      for (int k = 0; k < cnt; k++) begin
         // empty refuses data reads, not offset reads
         do @(posedge clk); while (rtick !== 1'b1 || (!off && empty_flag_n !== 1'b1));
         #1 check(data_out, base + 9'(k), "read word");
      end
      read_enable_a_n = 1'b1;
      read_enable_b_n = 1'b1;
      write_enable2_or_load = 1'b1;
   endtask

   // reads on an empty buffer must leave the output alone
   task automatic hold_read(input logic [8:0] last);
      #1 read_enable_a_n = 1'b0;
      read_enable_b_n = 1'b0;
      repeat (8) @(posedge clk);
      #1 check(data_out, last, "held word");
      read_enable_a_n = 1'b1;
      read_enable_b_n = 1'b1;
   endtask

   // verdict and end of run
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // tests
   initial begin
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      // two-enable mode, default offsets 7 and 7
      fifo_rst(1'b1);
      check({8'h00, data_out_oe}, 9'h001, "driving");
      put(3, 9'h1F0, 1'b0);
      flags_are(4'h3);
      put(7, 9'h100, 1'b1);
      flags_are(4'hB);
      put(1, 9'h107, 1'b1);
      flags_are(4'hF);
      put(48, 9'h108, 1'b1);
      flags_are(4'hF);
      put(1, 9'h138, 1'b1);
      flags_are(4'hE);
      put(7, 9'h139, 1'b1);
      flags_are(4'hC);
      put(1, 9'h0FF, 1'b1);
      get(DEPTH, 9'h100, 1'b0);
      hold_read(9'h13F);
      flags_are(4'h3);
      #1 output_drive_enable_n = 1'b1;
      @(posedge clk);
      #1 check({8'h00, data_out_oe}, 9'h000, "released");
      output_drive_enable_n = 1'b0;
      // reset with data present, into flag mode
      put(5, 9'h150, 1'b1);
      fifo_rst(1'b0);
      // load pin released between bytes; fifth byte wraps
      // an idle edge after each byte lets the design see the load pin high
      foreach (ofs_wr[i]) begin
         put(1, ofs_wr[i], 1'b0);
         @(posedge clk);
      end
      // never alongside an offset write
      foreach (ofs_rd[i]) get(1, ofs_rd[i], 1'b1);
      put(2, 9'h0A0, 1'b1);
      flags_are(4'hB);
      put(1, 9'h0A2, 1'b1);
      flags_are(4'hF);
      put(52, 9'h0A3, 1'b1);
      flags_are(4'hE);
      slow = 1'b1;
      get(55, 9'h0A0, 1'b0);
      slow = 1'b0;
      flags_are(4'h3);
      report_and_stop;
   end

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #50000;
      n_mismatch++;
      $display("mismatch at %0t: watchdog expired", $time);
      report_and_stop;
   end
endmodule
